// File: rscr_regs.sv
// rscr_regs: buck 2/4/5 setpoint registers and linear, buck 1 and
// buck 3 configuration registers of the power management device.
// assumes the serial engine presents byte requests on clk; straps and
// under-voltage detectors are asynchronous pins.
//
// Summary of operation
// - override bit picks register level, else straps
// - overcurrent-off bit disables buck overcurrent protection
// - buck 2: 1.500 V plus 37.5 mV steps
// - buck 4: 0.700 V, 25 mV; upper half separate
// - buck 5: 0.700 V plus 25 mV to 1.475
// - order field gives power-up position, capped sixth
// - two-bit slew field selects driver slew rate
// - low-side-off bit keeps synchronous switch off
// - linear deglitch bit: 10 us or 5 us
// - under-voltage mask bit is host read-only and stays clear, so faults pass
`timescale 1ns/10ps
module rscr_regs (
  // clock, reset, enable
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // register access from the serial engine
  input  wire rscr_pkg::rscr_host_req_t host_req,
  output logic [7:0]                  rd_data,
  output logic                        rd_valid,
  // strap pins
  input  wire logic                   strap_select_a,
  input  wire logic                   strap_select_b,
  // under-voltage detectors: 0 linear, 1 buck 1, 2 buck 3
  input  wire logic [2:0]             uv_detect,
  // buck setpoints
  output rscr_pkg::rscr_setpoint_t    buck2_sp,
  output rscr_pkg::rscr_setpoint_t    buck4_sp,
  output rscr_pkg::rscr_setpoint_t    buck5_sp,
  // regulator configuration
  output rscr_pkg::rscr_ldo_cfg_t     linear_cfg,
  output rscr_pkg::rscr_buck_cfg_t    buck1_cfg,
  output rscr_pkg::rscr_buck_cfg_t    buck3_cfg,
  // faults after masking, levels
  output logic [2:0]                  uv_fault
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and strap settle counter

  logic [1:0] strap_meta_ff;
  logic [1:0] strap_sync_ff;
  logic [2:0] uv_meta_ff;
  logic [2:0] uv_sync_ff;
  logic [1:0] settle_ff;
  logic [1:0] nxt_settle;
  logic       strap_load;

  always_comb begin
    nxt_settle = settle_ff;
    if (settle_ff != rscr_pkg::STRAP_DONE) begin
      nxt_settle = settle_ff + 2'h1;
    end
  end

  // strap caught only once the synchroniser has filled after reset
  assign strap_load = (settle_ff == rscr_pkg::STRAP_LOAD_AT);

  always_ff @(posedge clk) begin
    if (rst) begin
      strap_meta_ff <= 2'h0;
      strap_sync_ff <= 2'h0;
      uv_meta_ff    <= 3'h0;
      uv_sync_ff    <= 3'h0;
      settle_ff     <= 2'h0;
    end else if (ce) begin
      strap_meta_ff <= {strap_select_b, strap_select_a};
      strap_sync_ff <= strap_meta_ff;
      uv_meta_ff    <= uv_detect;
      uv_sync_ff    <= uv_meta_ff;
      settle_ff     <= nxt_settle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode

  logic       wr_b2;
  logic       wr_b4;
  logic       wr_b5;
  logic       wr_ldo;
  logic       wr_b1;
  logic       wr_b3;
  logic [7:0] wdata;

  assign wdata  = host_req.wdata;
  assign wr_b2  = host_req.wr && (host_req.addr == rscr_pkg::ADDR_BUCK2_SETPOINT);
  assign wr_b4  = host_req.wr && (host_req.addr == rscr_pkg::ADDR_BUCK4_SETPOINT);
  assign wr_b5  = host_req.wr && (host_req.addr == rscr_pkg::ADDR_BUCK5_SETPOINT);
  assign wr_ldo = host_req.wr && (host_req.addr == rscr_pkg::ADDR_LINEAR_CONFIG);
  assign wr_b1  = host_req.wr && (host_req.addr == rscr_pkg::ADDR_BUCK1_CONFIG);
  assign wr_b3  = host_req.wr && (host_req.addr == rscr_pkg::ADDR_BUCK3_CONFIG);

  ////////////////////////////////////////////////////////////////////////////
  // setpoint registers

  logic [7:0] b2_q;
  logic [7:0] b4_q;
  logic [7:0] b5_q;

  rscr_setpoint #(.LVL_W(5), .BASE(rscr_pkg::BUCK2_BASE), .STEP(rscr_pkg::BUCK2_STEP),
    .HI_BASE(rscr_pkg::BUCK2_BASE), .SPLIT(1'b0), .STRAP(rscr_pkg::BUCK2_STRAP)) u_buck2 (
    .clk(clk), .rst(rst), .ce(ce), .wr_en(wr_b2), .wdata(wdata), .strap_idx(strap_sync_ff),
    .strap_load(strap_load), .reg_q(b2_q), .sp(buck2_sp));
  rscr_setpoint #(.LVL_W(6), .BASE(rscr_pkg::BUCK4_BASE), .STEP(rscr_pkg::BUCK4_STEP),
    .HI_BASE(rscr_pkg::BUCK4_HI_BASE), .SPLIT(1'b1), .STRAP(rscr_pkg::BUCK4_STRAP)) u_buck4 (
    .clk(clk), .rst(rst), .ce(ce), .wr_en(wr_b4), .wdata(wdata), .strap_idx(strap_sync_ff),
    .strap_load(strap_load), .reg_q(b4_q), .sp(buck4_sp));
  rscr_setpoint #(.LVL_W(5), .BASE(rscr_pkg::BUCK5_BASE), .STEP(rscr_pkg::BUCK5_STEP),
    .HI_BASE(rscr_pkg::BUCK5_BASE), .SPLIT(1'b0), .STRAP(rscr_pkg::BUCK5_STRAP)) u_buck5 (
    .clk(clk), .rst(rst), .ce(ce), .wr_en(wr_b5), .wdata(wdata), .strap_idx(strap_sync_ff),
    .strap_load(strap_load), .reg_q(b5_q), .sp(buck5_sp));

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers and their decoded outputs

  logic [7:0]               ldo_ff;
  logic [7:0]               nxt_ldo;
  logic [7:0]               b1_ff;
  logic [7:0]               nxt_b1;
  logic [7:0]               b3_ff;
  logic [7:0]               nxt_b3;
  rscr_pkg::rscr_ldo_cfg_t  ldo_out_ff;
  rscr_pkg::rscr_ldo_cfg_t  nxt_ldo_out;
  rscr_pkg::rscr_buck_cfg_t b1_out_ff;
  rscr_pkg::rscr_buck_cfg_t nxt_b1_out;
  rscr_pkg::rscr_buck_cfg_t b3_out_ff;
  rscr_pkg::rscr_buck_cfg_t nxt_b3_out;

  // codes above the last slot all mean sixth
  function automatic logic [2:0] order_to_position(input logic [7:0] cfg);
    logic [2:0] order;
    order = cfg[rscr_pkg::CFG_ORDER_LSB +: 3];
    if (order > rscr_pkg::ORDER_LAST) begin
      return rscr_pkg::ORDER_LAST + 3'h1;
    end
    return order + 3'h1;
  endfunction

  // mask bit is host read-only, the rest of the byte stores as written
  function automatic logic [7:0] cfg_write(input logic [7:0] old, input logic [7:0] data);
    return {data[7:1], old[rscr_pkg::CFG_UV_MASK_BIT]};
  endfunction

  function automatic rscr_pkg::rscr_buck_cfg_t buck_decode(input logic [7:0] cfg);
    rscr_pkg::rscr_buck_cfg_t d;
    d.position     = order_to_position(cfg);
    d.slew         = cfg[rscr_pkg::CFG_SLEW_LSB +: 2];
    d.low_side_off = cfg[rscr_pkg::CFG_LOW_SIDE_BIT];
    d.uv_mask      = cfg[rscr_pkg::CFG_UV_MASK_BIT];
    return d;
  endfunction

  always_comb begin
    nxt_ldo = ldo_ff;
    nxt_b1  = b1_ff;
    nxt_b3  = b3_ff;
    if (wr_ldo) begin
      nxt_ldo = cfg_write(ldo_ff, wdata);
    end
    if (wr_b1) begin
      nxt_b1 = cfg_write(b1_ff, wdata);
    end
    if (wr_b3) begin
      nxt_b3 = cfg_write(b3_ff, wdata);
    end
    nxt_ldo_out.position     = order_to_position(nxt_ldo);
    nxt_ldo_out.filter_short = nxt_ldo[rscr_pkg::CFG_DEGLITCH_BIT];
    nxt_ldo_out.uv_mask      = nxt_ldo[rscr_pkg::CFG_UV_MASK_BIT];
    nxt_b1_out = buck_decode(nxt_b1);
    nxt_b3_out = buck_decode(nxt_b3);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ldo_ff     <= rscr_pkg::CFG_RESET;
      b1_ff      <= rscr_pkg::CFG_RESET;
      b3_ff      <= rscr_pkg::CFG_RESET;
      ldo_out_ff <= '{position: 3'h1, filter_short: 1'b0, uv_mask: 1'b0};
      b1_out_ff  <= '{position: 3'h1, slew: 2'h0, low_side_off: 1'b0, uv_mask: 1'b0};
      b3_out_ff  <= '{position: 3'h1, slew: 2'h0, low_side_off: 1'b0, uv_mask: 1'b0};
    end else if (ce) begin
      ldo_ff     <= nxt_ldo;
      b1_ff      <= nxt_b1;
      b3_ff      <= nxt_b3;
      ldo_out_ff <= nxt_ldo_out;
      b1_out_ff  <= nxt_b1_out;
      b3_out_ff  <= nxt_b3_out;
    end
  end

  assign linear_cfg = ldo_out_ff;
  assign buck1_cfg  = b1_out_ff;
  assign buck3_cfg  = b3_out_ff;

  ////////////////////////////////////////////////////////////////////////////
  // under-voltage fault path; linear fault needs a persisting condition

  logic [9:0] filt_ff;
  logic [9:0] nxt_filt;
  logic [9:0] filt_limit;
  logic [2:0] fault_ff;
  logic [2:0] nxt_fault;

  always_comb begin
    if (ldo_ff[rscr_pkg::CFG_DEGLITCH_BIT]) begin
      filt_limit = 10'(rscr_pkg::FILT_SHORT_CYC);
    end else begin
      filt_limit = 10'(rscr_pkg::FILT_LONG_CYC);
    end
    nxt_filt = 10'h000;
    if (uv_sync_ff[0]) begin
      nxt_filt = (filt_ff < filt_limit) ? filt_ff + 10'h001 : filt_limit;
    end
    nxt_fault[0] = (filt_ff >= filt_limit) && uv_sync_ff[0]
                   && !ldo_ff[rscr_pkg::CFG_UV_MASK_BIT];
    nxt_fault[1] = uv_sync_ff[1] && !b1_ff[rscr_pkg::CFG_UV_MASK_BIT];
    nxt_fault[2] = uv_sync_ff[2] && !b3_ff[rscr_pkg::CFG_UV_MASK_BIT];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      filt_ff  <= 10'h000;
      fault_ff <= 3'h0;
    end else if (ce) begin
      filt_ff  <= nxt_filt;
      fault_ff <= nxt_fault;
    end
  end

  assign uv_fault = fault_ff;

  ////////////////////////////////////////////////////////////////////////////
  // readback; unmapped offsets read as zero

  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       rvalid_ff;

  always_comb begin
    unique case (host_req.addr)
      rscr_pkg::ADDR_BUCK2_SETPOINT: nxt_rdata = b2_q;
      rscr_pkg::ADDR_BUCK4_SETPOINT: nxt_rdata = b4_q;
      rscr_pkg::ADDR_BUCK5_SETPOINT: nxt_rdata = b5_q;
      rscr_pkg::ADDR_LINEAR_CONFIG:  nxt_rdata = ldo_ff;
      rscr_pkg::ADDR_BUCK1_CONFIG:   nxt_rdata = b1_ff;
      rscr_pkg::ADDR_BUCK3_CONFIG:   nxt_rdata = b3_ff;
      default:                       nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else if (ce) begin
      rdata_ff  <= host_req.rd ? nxt_rdata : rdata_ff;
      rvalid_ff <= host_req.rd;
    end
  end

  assign rd_data  = rdata_ff;
  assign rd_valid = rvalid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  oc_write_a: assert property (
    @(posedge clk) disable iff (rst)
    (ce && wr_b4) |=> buck4_sp.overcurrent_off == $past(wdata[6]))
    else $error("overcurrent-off bit not stored");

  b2_target_a: assert property (
    @(posedge clk) disable iff (rst)
    buck2_sp.target == 16'h3A98 + 16'h0177 * {10'h000, buck2_sp.level})
    else $error("buck 2 target wrong");

  b4_target_a: assert property (
    @(posedge clk) disable iff (rst)
    !buck4_sp.level[5] |-> buck4_sp.target == 16'h1B58 + 16'h00FA * {10'h000, buck4_sp.level})
    else $error("buck 4 lower target wrong");

  b5_target_a: assert property (
    @(posedge clk) disable iff (rst)
    buck5_sp.level[4:0] == 5'h1F |-> buck5_sp.target == 16'h399E)
    else $error("buck 5 top code not 1.475 V");

  order_pos_a: assert property (
    @(posedge clk) disable iff (rst)
    (ce && wr_b1 && wdata[6:4] >= 3'h5) |=> buck1_cfg.position == 3'h6)
    else $error("order code not capped at sixth");

  slew_write_a: assert property (
    @(posedge clk) disable iff (rst)
    (ce && wr_b3) |=> buck3_cfg.slew == $past(wdata[3:2]))
    else $error("slew field not applied");

  low_side_a: assert property (
    @(posedge clk) disable iff (rst)
    (ce && wr_b1) |=> buck1_cfg.low_side_off == $past(wdata[1]))
    else $error("low-side-off not applied");

  filter_time_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(uv_fault[0]) |-> $past(filt_ff) == (ldo_ff[1] ? 10'h0FA : 10'h1F4))
    else $error("linear fault before filter time");

  uv_mask_a: assert property (
    @(posedge clk) disable iff (rst)
    ce |=> uv_fault[1] == ($past(uv_sync_ff[1]) && !$past(b1_ff[rscr_pkg::CFG_UV_MASK_BIT])))
    else $error("buck 1 fault does not follow mask");

  mask_ro_a: assert property (
    @(posedge clk) disable iff (rst)
    (ce && wr_ldo) |=> $stable(ldo_ff[0]))
    else $error("mask bit changed by host");

endmodule

// File: rscr_pkg.sv
// rscr_pkg: constants and carrier types for the regulator setpoint and
// configuration register block.
// assumes a single 50 MHz clock and an upstream serial engine on that clock.
package rscr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] ADDR_BUCK2_SETPOINT = 8'h03;
  localparam logic [7:0] ADDR_BUCK4_SETPOINT = 8'h04;
  localparam logic [7:0] ADDR_BUCK5_SETPOINT = 8'h05;
  localparam logic [7:0] ADDR_LINEAR_CONFIG  = 8'h06;
  localparam logic [7:0] ADDR_BUCK1_CONFIG   = 8'h07;
  localparam logic [7:0] ADDR_BUCK3_CONFIG   = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int SP_OVERRIDE_BIT  = 7;
  localparam int SP_OC_OFF_BIT    = 6;
  localparam int CFG_ORDER_LSB    = 4;
  localparam int CFG_SLEW_LSB     = 2;
  localparam int CFG_LOW_SIDE_BIT = 1;
  localparam int CFG_DEGLITCH_BIT = 1;
  localparam int CFG_UV_MASK_BIT  = 0;

  localparam logic [7:0] SP_RESET   = 8'h00;
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [2:0] ORDER_LAST = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // level code to target, in units of 0.1 mV
  localparam logic [15:0] BUCK2_BASE    = 16'h3A98;
  localparam logic [15:0] BUCK2_STEP    = 16'h0177;
  localparam logic [15:0] BUCK4_BASE    = 16'h1B58;
  localparam logic [15:0] BUCK4_STEP    = 16'h00FA;
  localparam logic [15:0] BUCK4_HI_BASE = 16'h62A2;
  localparam logic [15:0] BUCK5_BASE    = 16'h1B58;
  localparam logic [15:0] BUCK5_STEP    = 16'h00FA;

  // strap defaults, index {strap_select_b, strap_select_a}
  localparam logic [3:0][5:0] BUCK2_STRAP = {6'h00, 6'h00, 6'h00, 6'h00};
  localparam logic [3:0][5:0] BUCK4_STRAP = {6'h3F, 6'h10, 6'h0C, 6'h08};
  localparam logic [3:0][5:0] BUCK5_STRAP = {6'h14, 6'h10, 6'h0C, 6'h08};

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int FILT_LONG_NS   = 10000;
  localparam int FILT_SHORT_NS  = 5000;
  localparam int FILT_LONG_CYC  = (FILT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_SHORT_CYC = (FILT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] STRAP_LOAD_AT = 2'h2;
  localparam logic [1:0] STRAP_DONE    = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rscr_host_req_t;

  typedef struct packed {
    logic [5:0]  level;
    logic [15:0] target;
    logic        overcurrent_off;
  } rscr_setpoint_t;

  typedef struct packed {
    logic [2:0] position;
    logic [1:0] slew;
    logic       low_side_off;
    logic       uv_mask;
  } rscr_buck_cfg_t;

  typedef struct packed {
    logic [2:0] position;
    logic       filter_short;
    logic       uv_mask;
  } rscr_ldo_cfg_t;

endpackage

// File: rscr_setpoint.sv
// rscr_setpoint: one buck setpoint register with strap fallback and
// target computation.
// assumes strap_idx is already synchronised and strap_load is one cycle.
`timescale 1ns/10ps
module rscr_setpoint #(
  parameter int unsigned      LVL_W   = 5,
  parameter logic [15:0]      BASE    = rscr_pkg::BUCK5_BASE,
  parameter logic [15:0]      STEP    = rscr_pkg::BUCK5_STEP,
  parameter logic [15:0]      HI_BASE = rscr_pkg::BUCK4_HI_BASE,
  parameter bit               SPLIT   = 1'b0,
  parameter logic [3:0][5:0]  STRAP   = rscr_pkg::BUCK5_STRAP
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // register access
  input  wire logic                   wr_en,
  input  wire logic [7:0]             wdata,
  // strap selection
  input  wire logic [1:0]             strap_idx,
  input  wire logic                   strap_load,
  // readback and setpoint
  output logic [7:0]                  reg_q,
  output rscr_pkg::rscr_setpoint_t    sp
);

  logic [7:0]       reg_ff;
  logic [7:0]       nxt_reg;
  logic [5:0]       lvl_ff;
  logic [5:0]       nxt_lvl;
  logic [15:0]      tgt_ff;
  logic [15:0]      nxt_tgt;
  logic [LVL_W-1:0] wcode;

  // upper half of a split field is its own range
  function automatic logic [15:0] level_to_target(input logic [5:0] code);
    logic [15:0] low;
    low = {11'h000, code[4:0]};
    if (SPLIT && code[5]) begin
      return HI_BASE + STEP * low;
    end
    return BASE + STEP * {10'h000, code};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_reg = reg_ff;
    if (strap_load) begin
      nxt_reg[LVL_W-1:0] = STRAP[strap_idx][LVL_W-1:0];
    end
    if (wr_en) begin
      nxt_reg = wdata;
    end
    if (reg_ff[rscr_pkg::SP_OVERRIDE_BIT]) begin
      nxt_lvl = 6'(reg_ff[LVL_W-1:0]);
    end else begin
      nxt_lvl = 6'(STRAP[strap_idx][LVL_W-1:0]);
    end
    nxt_tgt = level_to_target(nxt_lvl);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_ff <= rscr_pkg::SP_RESET;
      lvl_ff <= 6'h00;
      tgt_ff <= BASE;
    end else if (ce) begin
      reg_ff <= nxt_reg;
      lvl_ff <= nxt_lvl;
      tgt_ff <= nxt_tgt;
    end
  end

  assign reg_q = reg_ff;
  assign sp    = '{level: lvl_ff, target: tgt_ff,
                   overcurrent_off: reg_ff[rscr_pkg::SP_OC_OFF_BIT]};
  assign wcode = wdata[LVL_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  override_level_a: assert property (
    @(posedge clk) disable iff (rst)
    (ce && wr_en && wdata[rscr_pkg::SP_OVERRIDE_BIT]) ##1 ce
      |=> sp.level[LVL_W-1:0] == $past(wcode, 2))
    else $error("override level not applied");

  strap_level_a: assert property (
    @(posedge clk) disable iff (rst)
    (ce && !reg_ff[rscr_pkg::SP_OVERRIDE_BIT])
      |=> sp.level[LVL_W-1:0] == STRAP[$past(strap_idx)][LVL_W-1:0])
    else $error("strap level not followed");

  strap_load_a: assert property (
    @(posedge clk) disable iff (rst)
    (ce && strap_load && !wr_en)
      |=> reg_q[LVL_W-1:0] == STRAP[$past(strap_idx)][LVL_W-1:0])
    else $error("strap default not loaded");

endmodule

// File: rscr_host_model.sv
// rscr_host_model: byte-level host standing in for the serial engine.
// assumes the bench calls one task at a time, from the clk domain.
`timescale 1ns/10ps
module rscr_host_model (
  // clock
  input  wire logic                clk,
  // register bus
  output rscr_pkg::rscr_host_req_t req,
  input  wire logic [7:0]          rd_data,
  input  wire logic                rd_valid
);
  initial req = '{wr: 1'b0, rd: 1'b0, addr: 8'hFF, wdata: 8'hFF};

  //////////////////////////////////////////////////////////////////////////
  // gap idles the bus first, so a slow host is one argument away
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    // released lines flip so stale values cannot pass for live ones
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd_byte(input logic [7:0] a, input int gap, output logic [7:0] d,
                         output logic v);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    #1;
    v = rd_valid;
    d = rd_data;
  endtask
endmodule

// File: testbench.sv
// testbench: self-checking bench for the setpoint and configuration registers.
// assumes one 50 MHz clock; the host model owns the register bus.
`timescale 1ns/10ps
module testbench;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic                     ce = 1'b1;
  logic                     sel_a = 1'b0;
  logic                     sel_b = 1'b1;
  logic [2:0]               uv_detect = 3'h0;
  logic [2:0]               uv_fault;
  rscr_pkg::rscr_host_req_t req;
  logic [7:0]               rd_data;
  logic                     rd_valid;
  rscr_pkg::rscr_setpoint_t b2, b4, b5;
  rscr_pkg::rscr_ldo_cfg_t  lin;
  rscr_pkg::rscr_buck_cfg_t c1, c3;
  int                       bad_count = 0;
  int                       num_checks = 0;
  int                       cycles = 0;

  always #10 clk = ~clk;

  rscr_regs rscr_regs_i (.clk(clk), .rst(rst), .ce(ce), .host_req(req),
    .rd_data(rd_data), .rd_valid(rd_valid), .strap_select_a(sel_a),
    .strap_select_b(sel_b), .uv_detect(uv_detect), .buck2_sp(b2), .buck4_sp(b4),
    .buck5_sp(b5), .linear_cfg(lin), .buck1_cfg(c1), .buck3_cfg(c3),
    .uv_fault(uv_fault));
  rscr_host_model rscr_host_model_i (.clk(clk), .req(req), .rd_data(rd_data),
    .rd_valid(rd_valid));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rscr_host_model_i.wr_byte(a, d, 0);
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    rscr_host_model_i.rd_byte(a, 1, d, v);
    check("rd_valid", 16'(v), 16'h0001);
    check("rd_data", 16'(d), 16'(exp));
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rd_chk(rscr_pkg::ADDR_BUCK2_SETPOINT, 8'(rscr_pkg::BUCK2_STRAP[2]));
    rd_chk(rscr_pkg::ADDR_BUCK4_SETPOINT, 8'(rscr_pkg::BUCK4_STRAP[2]));
    rd_chk(rscr_pkg::ADDR_LINEAR_CONFIG, 8'h00);
    rd_chk(rscr_pkg::ADDR_BUCK1_CONFIG, 8'h00);
    rd_chk(rscr_pkg::ADDR_BUCK3_CONFIG, 8'h00);
    check("b4 level", 16'(b4.level), 16'(rscr_pkg::BUCK4_STRAP[2]));
    check("b4 target", b4.target, 16'h2AF8);
    check("b2 oc", 16'(b2.overcurrent_off), 16'h0000);
  endtask

  task automatic test_setpoint();
    wr(rscr_pkg::ADDR_BUCK2_SETPOINT, 8'h85);
    check("b2 level", 16'(b2.level), 16'h0005);
    check("b2 target", b2.target, 16'h41EB);
    wr(rscr_pkg::ADDR_BUCK2_SETPOINT, 8'h5F);
    check("b2 strap", 16'(b2.level), 16'(rscr_pkg::BUCK2_STRAP[2]));
    check("b2 oc", 16'(b2.overcurrent_off), 16'h0001);
    wr(rscr_pkg::ADDR_BUCK2_SETPOINT, 8'hBF);
    check("b2 top", b2.target, 16'h6801);
    check("b2 oc off", 16'(b2.overcurrent_off), 16'h0000);
    rd_chk(rscr_pkg::ADDR_BUCK2_SETPOINT, 8'hBF);
    wr(rscr_pkg::ADDR_BUCK4_SETPOINT, 8'h81);
    check("b4 low", b4.target, 16'h1C52);
    // top code of the upper range is 3.300 V
    wr(rscr_pkg::ADDR_BUCK4_SETPOINT, 8'hBF);
    check("b4 high", b4.target, 16'h80E8);
    wr(rscr_pkg::ADDR_BUCK5_SETPOINT, 8'h9F);
    check("b5 top", b5.target, 16'h399E);
    wr(rscr_pkg::ADDR_BUCK5_SETPOINT, 8'hC0);
    check("b5 base", b5.target, 16'h1B58);
    check("b5 oc", 16'(b5.overcurrent_off), 16'h0001);
    wr(rscr_pkg::ADDR_BUCK5_SETPOINT, 8'h1F);
    @(posedge clk);
    sel_b <= 1'b0;
    sel_a <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check("b5 live", 16'(b5.level), 16'(rscr_pkg::BUCK5_STRAP[1]));
  endtask

  task automatic test_config();
    logic [2:0] p;
    wr(rscr_pkg::ADDR_BUCK1_CONFIG, 8'h5B);
    rd_chk(rscr_pkg::ADDR_BUCK1_CONFIG, 8'h5A);
    check("c1 pos", 16'(c1.position), 16'h0006);
    check("c1 slew", 16'(c1.slew), 16'h0002);
    check("c1 ls", 16'(c1.low_side_off), 16'h0001);
    check("c1 mask", 16'(c1.uv_mask), 16'h0000);
    for (int c = 0; c < 8; c++) begin
      p = 3'(c);
      wr(rscr_pkg::ADDR_BUCK3_CONFIG, {1'b1, p, p[1:0], 2'h0});
      check("c3 pos", 16'(c3.position), (c > 5) ? 16'h0006 : 16'(c + 1));
      check("c3 slew", 16'(c3.slew), 16'(c % 4));
    end
    check("c3 ls", 16'(c3.low_side_off), 16'h0000);
    wr(rscr_pkg::ADDR_LINEAR_CONFIG, 8'h8F);
    rd_chk(rscr_pkg::ADDR_LINEAR_CONFIG, 8'h8E);
    check("lin short", 16'(lin.filter_short), 16'h0001);
    check("lin mask", 16'(lin.uv_mask), 16'h0000);
    check("lin pos", 16'(lin.position), 16'h0001);
    wr(8'h20, 8'hFF);
    rd_chk(8'h20, 8'h00);
    rd_chk(rscr_pkg::ADDR_BUCK1_CONFIG, 8'h5A);
    // enable low: a write must leave every register frozen
    @(posedge clk);
    ce <= 1'b0;
    wr(rscr_pkg::ADDR_BUCK1_CONFIG, 8'h02);
    @(posedge clk);
    ce <= 1'b1;
    rd_chk(rscr_pkg::ADDR_BUCK1_CONFIG, 8'h5A);
    check("c1 frozen", 16'(c1.slew), 16'h0002);
  endtask

  task automatic test_fault();
    @(posedge clk);
    uv_detect <= 3'h6;
    repeat (2) @(posedge clk);
    #1;
    check("uv early", 16'(uv_fault), 16'h0000);
    @(posedge clk);
    #1;
    check("uv bucks", 16'(uv_fault), 16'h0006);
    // deglitch was left at the short setting by the config scenario
    @(posedge clk);
    uv_detect <= 3'h1;
    repeat (200) @(posedge clk);
    #1;
    check("lin filt", 16'(uv_fault[0]), 16'h0000);
    repeat (100) @(posedge clk);
    #1;
    check("lin fault", 16'(uv_fault[0]), 16'h0001);
    // long filter: last position, deglitch bit clear
    @(posedge clk);
    uv_detect <= 3'h0;
    wr(rscr_pkg::ADDR_LINEAR_CONFIG, 8'hE0);
    check("lin pos", 16'(lin.position), 16'h0006);
    check("uv clear", 16'(uv_fault), 16'h0000);
    @(posedge clk);
    uv_detect <= 3'h1;
    repeat (450) @(posedge clk);
    #1;
    check("lin long filt", 16'(uv_fault[0]), 16'h0000);
    repeat (100) @(posedge clk);
    #1;
    check("lin long fault", 16'(uv_fault[0]), 16'h0001);
  endtask

  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    test_reset();
    test_setpoint();
    test_config();
    test_fault();
    conclude();
  end
endmodule
